/* rtl/jaiex_exec.sv */
// Execution logic for the absolute jump and the increment file register instructions.
`timescale 1ns/1ps
// Contract
// [RULE1] Jump loads 20-bit literal into PC 20:1.
// [RULE2] Jump is two words, two cycles, second idle.
// [RULE3] Increment reads register, adds one, delivers sum.
// [RULE4] Dest bit 0: result to accumulator only.
// [RULE5] Dest bit 1: result back to register.
// [RULE6] Access bit 0: use fixed access bank.
// [RULE7] Access bit 1: bank select register picks bank.
// [RULE8] Extended set, access 0, f<=95: indexed offset.
// [RULE9] Increment single word, updates five status flags.
module jaiex_exec
  import jaiex_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [BANK_W-1:0] bank_select_reg_i,
  input wire logic [DADDR_W-1:0] index_base_i,
  input wire logic [DATA_W-1:0] dmem_rdata_i,
  output logic instr_ready_o,
  output logic [PC_W-1:0] pc_o,
  output logic pc_load_o,
  output logic dmem_rd_o,
  output logic [DADDR_W-1:0] dmem_raddr_o,
  output jaiex_dwrite_s dmem_wr_o,
  output logic wreg_we_o,
  output logic [DATA_W-1:0] wreg_o,
  output logic status_we_o,
  output jaiex_flags_s status_o,
  output logic illegal_o
);

  jaiex_state_e state_reg, state_next;
  logic ready_reg, ready_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic pc_load_reg, pc_load_next;
  logic [7:0] lit_low_reg, lit_low_next;
  logic rd_reg, rd_next;
  logic [DADDR_W-1:0] raddr_reg, raddr_next;
  logic dest_reg, dest_next;
  jaiex_dwrite_s dwr_reg, dwr_next;
  logic wreg_we_reg, wreg_we_next;
  logic [DATA_W-1:0] wreg_reg, wreg_next;
  logic status_we_reg, status_we_next;
  jaiex_flags_s status_reg, status_next;
  logic illegal_reg, illegal_next;

  logic take;
  logic is_jump_w1;
  logic is_jump_w2;
  logic is_inc;
  logic [7:0] f_addr;
  logic [DADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] inc_result;
  jaiex_flags_s inc_flags;

  jaiex_inc_alu u_alu (
    .operand_i(dmem_rdata_i),
    .result_o(inc_result),
    .flags_o(inc_flags)
  );

  // Effective data address of an increment; the four cases are mutually exclusive.
  always_comb begin
    f_addr = instr_i[7:0];
    if (instr_i[ACCESS_BIT] == ACCESS_BANKED) begin
      eff_addr = {bank_select_reg_i, f_addr}; // [RULE7]
    end else if (ext_set_en_i && (f_addr <= ACCESS_LOW_LIMIT)) begin
      // The index base is added as an unsigned offset and wraps within the data space.
      eff_addr = index_base_i + {{(DADDR_W-8){1'b0}}, f_addr}; // [RULE8]
    end else if (f_addr <= ACCESS_LOW_LIMIT) begin
      eff_addr = {ACCESS_LOW_BANK, f_addr}; // [RULE6]
    end else begin
      eff_addr = {ACCESS_HIGH_BANK, f_addr}; // [RULE6]
    end
  end

  always_comb begin
    take = instr_valid_i && ready_reg;
    is_jump_w1 = (instr_i[INSTR_W-1:8] == JUMP_W1_OPCODE);
    is_jump_w2 = (instr_i[INSTR_W-1:12] == JUMP_W2_MARK);
    is_inc = (instr_i[INSTR_W-1:INC_OPC_LSB] == INC_OPCODE); // [RULE9]
  end

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    lit_low_next = lit_low_reg;
    rd_next = 1'b0;
    raddr_next = raddr_reg;
    dest_next = dest_reg;
    dwr_next = dwr_reg;
    dwr_next.en = 1'b0;
    wreg_we_next = 1'b0;
    wreg_next = wreg_reg;
    status_we_next = 1'b0;
    status_next = status_reg;
    illegal_next = 1'b0;
    case (state_reg)
      JAIEX_ST_DECODE: begin
        if (take && is_jump_w1) begin
          lit_low_next = instr_i[7:0];
          state_next = JAIEX_ST_JUMP_WORD2; // [RULE2]
        end else if (take && is_inc) begin
          rd_next = 1'b1; // [RULE3]
          raddr_next = eff_addr;
          dest_next = instr_i[DEST_BIT];
          state_next = JAIEX_ST_INC_EXEC;
        end else if (take) begin
          illegal_next = 1'b1;
        end
      end
      JAIEX_ST_INC_EXEC: begin
        status_we_next = 1'b1; // [RULE9]
        status_next = inc_flags;
        if (dest_reg == DEST_WREG) begin
          wreg_we_next = 1'b1; // [RULE4]
          wreg_next = inc_result;
        end else begin
          dwr_next.en = 1'b1; // [RULE5]
          dwr_next.addr = raddr_reg;
          dwr_next.data = inc_result;
        end
        state_next = JAIEX_ST_DECODE;
      end
      JAIEX_ST_JUMP_WORD2: begin
        if (take && is_jump_w2) begin
          pc_next = {instr_i[11:0], lit_low_reg, 1'b0}; // [RULE1]
          pc_load_next = 1'b1;
          state_next = JAIEX_ST_JUMP_NOP; // [RULE2]
        end else if (take) begin
          // A broken second word abandons the jump rather than branching to garbage.
          illegal_next = 1'b1;
          state_next = JAIEX_ST_DECODE;
        end
      end
      JAIEX_ST_JUMP_NOP: begin
        state_next = JAIEX_ST_DECODE; // [RULE2]
      end
      default: begin
        state_next = JAIEX_ST_DECODE;
      end
    endcase
    ready_next = (state_next == JAIEX_ST_DECODE) || (state_next == JAIEX_ST_JUMP_WORD2);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= JAIEX_ST_DECODE;
      ready_reg <= 1'b0;
      pc_reg <= PC_RESET;
      pc_load_reg <= 1'b0;
      lit_low_reg <= '0;
      rd_reg <= 1'b0;
      raddr_reg <= '0;
      dest_reg <= DEST_FILE;
      dwr_reg <= '0;
      wreg_we_reg <= 1'b0;
      wreg_reg <= '0;
      status_we_reg <= 1'b0;
      status_reg <= '0;
      illegal_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      lit_low_reg <= lit_low_next;
      rd_reg <= rd_next;
      raddr_reg <= raddr_next;
      dest_reg <= dest_next;
      dwr_reg <= dwr_next;
      wreg_we_reg <= wreg_we_next;
      wreg_reg <= wreg_next;
      status_we_reg <= status_we_next;
      status_reg <= status_next;
      illegal_reg <= illegal_next;
    end
  end

  always_comb begin
    instr_ready_o = ready_reg;
    pc_o = pc_reg;
    pc_load_o = pc_load_reg;
    dmem_rd_o = rd_reg;
    dmem_raddr_o = raddr_reg;
    dmem_wr_o = dwr_reg;
    wreg_we_o = wreg_we_reg;
    wreg_o = wreg_reg;
    status_we_o = status_we_reg;
    status_o = status_reg;
    illegal_o = illegal_reg;
  end

endmodule : jaiex_exec

/* rtl/jaiex_inc_alu.sv */
// Eight-bit increment datapath with its status flag outputs.
`timescale 1ns/1ps
module jaiex_inc_alu
  import jaiex_pkg::*;
(
  input wire logic [DATA_W-1:0] operand_i,
  output logic [DATA_W-1:0] result_o,
  output jaiex_flags_s flags_o
);

  logic [DATA_W:0] sum;

  always_comb begin
    sum = {1'b0, operand_i} + {1'b0, DATA_ONE}; // [RULE3]
    result_o = sum[DATA_W-1:0];
    flags_o.carry = sum[DATA_W]; // [RULE9]
    flags_o.digit_carry = (operand_i[3:0] == NIBBLE_MAX);
    flags_o.negative = sum[DATA_W-1];
    // Only the largest positive value can overflow when one is added.
    flags_o.overflow = (operand_i == SIGNED_MAX);
    flags_o.zero = (sum[DATA_W-1:0] == '0);
  end

endmodule : jaiex_inc_alu

/* rtl/jaiex_pkg.sv */
// Shared constants and carrier types for the jump and increment execution block.
package jaiex_pkg;

  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned PC_W = 21;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned JUMP_LIT_W = 20;

  // Absolute jump, first word: opcode byte then literal bits 7..0.
  localparam logic [7:0] JUMP_W1_OPCODE = 8'hEF;
  // Absolute jump, second word: marker nibble then literal bits 19..8.
  localparam logic [3:0] JUMP_W2_MARK = 4'hF;
  // Increment file register: six opcode bits, then dest, access, and the address byte.
  localparam logic [5:0] INC_OPCODE = 6'h0A;
  localparam int unsigned INC_OPC_LSB = 10;
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACCESS_BIT = 8;

  localparam logic DEST_WREG = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic ACCESS_FIXED = 1'b0;
  localparam logic ACCESS_BANKED = 1'b1;

  // Fixed access bank: addresses up to this limit map to bank 0, the rest to the top bank.
  localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] SIGNED_MAX = 8'h7F;
  localparam logic [3:0] NIBBLE_MAX = 4'hF;

  typedef enum logic [1:0] {
    JAIEX_ST_DECODE = 2'b00,
    JAIEX_ST_INC_EXEC = 2'b01,
    JAIEX_ST_JUMP_WORD2 = 2'b10,
    JAIEX_ST_JUMP_NOP = 2'b11
  } jaiex_state_e;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic negative;
    logic overflow;
    logic zero;
  } jaiex_flags_s;

  typedef struct packed {
    logic en;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } jaiex_dwrite_s;

endpackage : jaiex_pkg

/* verification/jaiex_exec_checker.sv */
// Concurrent checks on the jump and increment execution ports.
`timescale 1ns/1ps
module jaiex_exec_checker
  import jaiex_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [BANK_W-1:0] bank_select_reg_i,
  input wire logic [DADDR_W-1:0] index_base_i,
  input wire logic instr_ready_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic pc_load_o,
  input wire logic dmem_rd_o,
  input wire logic [DADDR_W-1:0] dmem_raddr_o,
  input wire jaiex_dwrite_s dmem_wr_o,
  input wire logic wreg_we_o,
  input wire logic status_we_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [INSTR_W-1:0] w1_q, w2_q;
  wire logic take = instr_valid_i && instr_ready_o;
  // A word taken right after a jump's first word is its second word, never a new instruction.
  logic jump_pend_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      jump_pend_q <= 1'b0;
    end else if (take) begin
      jump_pend_q <= !jump_pend_q && (instr_i[15:8] == JUMP_W1_OPCODE);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    w1_q <= instr_i;
    w2_q <= w1_q;
  end
  sequence jump_s;
    take && !jump_pend_q && instr_i[15:8] == JUMP_W1_OPCODE ##1
      take && instr_i[15:12] == JUMP_W2_MARK;
  endsequence
  sequence inc_s;
    take && !jump_pend_q && instr_i[15:10] == INC_OPCODE;
  endsequence
  jump_target_a: assert property (jump_s |=> pc_load_o && pc_o == {w1_q[11:0], w2_q[7:0], 1'b0})
    else $error("jump target wrong");
  jump_idle_a: assert property (jump_s |=> !instr_ready_o ##1 instr_ready_o && !pc_load_o)
    else $error("jump idle cycle wrong");
  inc_read_a: assert property (inc_s |=> dmem_rd_o && !instr_ready_o ##1 status_we_o)
    else $error("increment read wrong");
  inc_wreg_a: assert property ((inc_s and !instr_i[DEST_BIT]) |-> ##2 wreg_we_o && !dmem_wr_o.en)
    else $error("accumulator write wrong");
  inc_file_a: assert property ((inc_s and instr_i[DEST_BIT]) |-> ##2 dmem_wr_o.en && !wreg_we_o
    && dmem_wr_o.addr == dmem_raddr_o)
    else $error("file write wrong");
  bank_fixed_a: assert property ((inc_s and (!instr_i[ACCESS_BIT] && !ext_set_en_i)) |=> dmem_raddr_o
    == {(w1_q[7:0] > ACCESS_LOW_LIMIT) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK, w1_q[7:0]})
    else $error("access bank address wrong");
  bank_sel_a: assert property ((inc_s and instr_i[ACCESS_BIT]) |=>
    dmem_raddr_o == {$past(bank_select_reg_i), w1_q[7:0]})
    else $error("banked address wrong");
  indexed_a: assert property ((inc_s and (!instr_i[ACCESS_BIT] && ext_set_en_i && instr_i[7:0] <=
    ACCESS_LOW_LIMIT)) |=> dmem_raddr_o == $past(index_base_i) + DADDR_W'(w1_q[7:0]))
    else $error("indexed address wrong");
endmodule : jaiex_exec_checker

bind jaiex_exec jaiex_exec_checker jaiex_exec_checker_i (.clk_sys_i, .rst_i, .instr_valid_i,
  .instr_i, .ext_set_en_i, .bank_select_reg_i, .index_base_i, .instr_ready_o, .pc_o,
  .pc_load_o, .dmem_rd_o, .dmem_raddr_o, .dmem_wr_o, .wreg_we_o, .status_we_o);

/* verification/jaiex_exec_tb.sv */
// Self-checking bench for the jump and increment execution block.
`timescale 1ns/1ps
module jaiex_exec_tb;
  import jaiex_pkg::*;
  logic clk_sys_i, rst_i, instr_valid_i, ext_set_en_i, instr_ready_o, pc_load_o;
  logic dmem_rd_o, wreg_we_o, status_we_o, illegal_o;
  logic [INSTR_W-1:0] instr_i;
  logic [BANK_W-1:0] bank_select_reg_i;
  logic [DADDR_W-1:0] index_base_i, dmem_raddr_o, ea;
  logic [DATA_W-1:0] dmem_rdata_i, wreg_o, sum;
  logic [PC_W-1:0] pc_o, pc_exp;
  jaiex_dwrite_s dmem_wr_o;
  jaiex_flags_s status_o;
  int mismatches, comparisons, seed, i;
  jaiex_exec jaiex_exec_i (.clk_sys_i, .rst_i, .instr_valid_i, .instr_i, .ext_set_en_i,
    .bank_select_reg_i, .index_base_i, .dmem_rdata_i, .instr_ready_o, .pc_o, .pc_load_o,
    .dmem_rd_o, .dmem_raddr_o, .dmem_wr_o, .wreg_we_o, .wreg_o, .status_we_o, .status_o,
    .illegal_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic inc(logic d, logic a, logic [7:0] f, logic [7:0] rd);
    check("ready", instr_ready_o, 1);
    instr_valid_i = 1'b1;
    instr_i = {INC_OPCODE, d, a, f};
    {ext_set_en_i, bank_select_reg_i, index_base_i} = 17'($random(seed));
    if (a) ea = {bank_select_reg_i, f};
    else if (ext_set_en_i && f <= 8'h5F) ea = index_base_i + DADDR_W'(f);
    else ea = {(f > 8'h5F) ? 4'hF : 4'h0, f};
    sum = rd + 8'h01;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    dmem_rdata_i = rd;
    check("read", {dmem_rd_o, instr_ready_o, illegal_o, dmem_raddr_o}, {3'b100, ea});
    @(negedge clk_sys_i);
    check("flags", {status_we_o, status_o}, {1'b1, rd == 8'hFF, rd[3:0] == 4'hF, sum[7],
      rd == 8'h7F, sum == 8'h00});
    check("write", {wreg_we_o, dmem_wr_o.en, (d ? {dmem_wr_o.addr, dmem_wr_o.data} :
      {ea, wreg_o})}, {~d, d, ea, sum});
  endtask : inc
  // A bad second word must abandon the jump and leave the counter alone.
  task automatic jump(logic [19:0] k, logic bad);
    instr_valid_i = 1'b1;
    instr_i = {JUMP_W1_OPCODE, k[7:0]};
    @(negedge clk_sys_i);
    instr_i = bad ? 16'h2A00 : {JUMP_W2_MARK, k[19:8]};
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    if (!bad) pc_exp = {k, 1'b0};
    check("jump", {pc_load_o, illegal_o, dmem_rd_o, instr_ready_o, pc_o},
      {~bad, bad, 1'b0, bad, pc_exp});
    @(negedge clk_sys_i);
    check("idle", {pc_load_o, instr_ready_o}, 2'b01);
  endtask : jump
  initial begin
    seed = 32'h65a0_dfc5;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    {ext_set_en_i, bank_select_reg_i, index_base_i} = '0;
    dmem_rdata_i = '0;
    pc_exp = '0;
    repeat (10) @(negedge clk_sys_i);
    check("reset", {instr_ready_o, pc_o, dmem_wr_o, wreg_o}, '0);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    inc(1'b1, 1'b0, 8'h5F, 8'hFF);
    inc(1'b0, 1'b0, 8'h60, 8'h7F);
    inc(1'b1, 1'b1, 8'h00, 8'h0F);
    // A neighbouring opcode must not be mistaken for an increment.
    instr_valid_i = 1'b1;
    instr_i = 16'h2400;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    check("other", {illegal_o, instr_ready_o, dmem_rd_o, pc_load_o}, 4'b1100);
    for (i = 0; i < 80; i++) begin
      inc(1'($random(seed)), 1'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    jump(20'hF_FFFF, 1'b0);
    jump(20'h0_0001, 1'b1);
    for (i = 0; i < 20; i++) jump(20'($random(seed)), 1'b0);
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    mismatches++;
    finish_test();
  end
endmodule : jaiex_exec_tb
